/* File: rtl/cie_pkg.sv */
// ==========================================================================
// shared constants and state types for the interrupt enable and flag logic
// ==========================================================================
package cie_pkg;

   // register indexes on the plain register port
   localparam logic [2:0] ADDR_CTRL   = 3'h0; // interrupt_control
   localparam logic [2:0] ADDR_PIE    = 3'h1; // peripheral_interrupt_enables
   localparam logic [2:0] ADDR_PIR    = 3'h2; // peripheral_interrupt_flags
   localparam logic [2:0] ADDR_PCM    = 3'h3; // pin_change_enable_mask
   localparam logic [2:0] ADDR_OPT    = 3'h4; // option bits (edge select)
   localparam logic [2:0] ADDR_EVT_ST = 3'h5; // block event status, w1c
   localparam logic [2:0] ADDR_EVT_MK = 3'h6; // block event mask

   // interrupt_control field positions
   localparam int unsigned BIT_GIE  = 7; // global_irq_enable
   localparam int unsigned BIT_PERIPHERAL_GROUP_ENABLE = 6; // peripheral_group_enable
   localparam int unsigned BIT_TAE  = 5; // timer_a_overflow_enable
   localparam int unsigned BIT_EXE  = 4; // ext pin interrupt enable
   localparam int unsigned BIT_PCE  = 3; // port_change_enable
   localparam int unsigned BIT_TAF  = 2; // timer_a_overflow_flag
   localparam int unsigned BIT_EXF  = 1; // ext_pin_irq_flag
   localparam int unsigned BIT_PCF  = 0; // port_change_flag

   // peripheral flag positions that mirror peripheral levels, then option and event status bit positions
   localparam int unsigned BIT_RX   = 5; // serial receive buffer full
   localparam int unsigned BIT_TX   = 4; // serial transmit buffer empty
   localparam logic [7:0]  PIR_RO   = 8'h30; // bits software cannot write
   localparam int unsigned BIT_EDGE = 6; // ext_edge_select in option reg
   localparam int unsigned BIT_BUSY = 7; // service state in event status

   // block event status bits
   localparam int unsigned EVT_REQ  = 0; // request to core rose
   localparam int unsigned EVT_ACK  = 1; // core accepted an interrupt
   localparam int unsigned EVT_RET  = 2; // core returned from service

   // reset values
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] PIE_RST  = 8'h00;
   localparam logic [7:0] PIR_RST  = 8'h00;
   localparam logic [7:0] PCM_RST  = 8'h00;
   localparam logic [7:0] OPT_RST  = 8'h00;
   localparam logic [2:0] EVT_RST  = 3'h0;

   // core service state, gray along idle -> busy
   typedef enum logic [1:0] {
      SVC_IDLE = 2'b00,
      SVC_BUSY = 2'b01
   } cie_svc_e;

   typedef struct packed {
      cie_svc_e   svc;    // service state
      logic [7:0] ctrl;   // interrupt_control
      logic [7:0] pie;    // peripheral_interrupt_enables
      logic [7:0] pir;    // peripheral_interrupt_flags
      logic [7:0] pcm;    // pin_change_enable_mask
      logic [7:0] opt;    // option bits
      logic [2:0] evt_st; // sticky block events
      logic [2:0] evt_mk; // block event mask
      logic [7:0] rdata;  // read data register
      logic       req;    // request to core
      logic       irq;    // block interrupt output
   } cie_top_s;

   typedef struct packed {
      logic prev;   // pin level last cycle
      logic primed; // prev holds a real sample
      logic pulse;  // edge seen
   } cie_edge_s;

   typedef struct packed {
      logic [7:0] prev;
      logic       primed;
      logic       pulse;
   } cie_chg_s;

   // any source whose enable and flag are both set
   function automatic logic any_hit(input logic [7:0] en,
                                    input logic [7:0] fl);
      any_hit = |(en & fl);
   endfunction

endpackage

/* File: rtl/cie_edge_detect.sv */
`timescale 1ns/10ps
// ==========================================================================
// edge detector for the external interrupt pin
// ==========================================================================
module cie_edge_detect (
   // clock and reset
   input  wire logic ref_clk,
   input  wire logic rst_n,
   input  wire logic ce,
   // pin and edge choice
   input  wire logic pin,
   input  wire logic rise_sel,
   // one-cycle edge pulse
   output logic      edge_pulse
);
   import cie_pkg::*;

   cie_edge_s s_reg;  // all state
   cie_edge_s s_next; // next state

   // first sample after reset only primes, so a pin that starts
   // high is not taken for a rising edge
   always_comb begin
      s_next = s_reg;
      s_next.prev = pin;
      s_next.primed = 1'b1;
      if (rise_sel) begin
         s_next.pulse = s_reg.primed & pin & ~s_reg.prev; // see R15
      end else begin
         s_next.pulse = s_reg.primed & ~pin & s_reg.prev; // see R15
      end
   end

   // state register
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         s_reg <= '0;
      end else if (ce) begin
         s_reg <= s_next;
      end
   end

   assign edge_pulse = s_reg.pulse;
endmodule

/* File: rtl/cie_pin_change.sv */
`timescale 1ns/10ps
// ==========================================================================
// change detector for the general purpose port pins
// ==========================================================================
module cie_pin_change (
   // clock and reset
   input  wire logic       ref_clk,
   input  wire logic       rst_n,
   input  wire logic       ce,
   // pins and per-pin enables
   input  wire logic [7:0] pins,
   input  wire logic [7:0] mask,
   // one-cycle change pulse
   output logic            change_pulse
);
   import cie_pkg::*;

   cie_chg_s s_reg;  // all state
   cie_chg_s s_next; // next state

   // only pins whose change enable is set may report
   always_comb begin
      s_next = s_reg;
      s_next.prev = pins;
      s_next.primed = 1'b1;
      s_next.pulse = s_reg.primed & any_hit(mask, pins ^ s_reg.prev); // see R5
   end

   // state register
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         s_reg <= '0;
      end else if (ce) begin
         s_reg <= s_next;
      end
   end

   assign change_pulse = s_reg.pulse;
endmodule

/* File: rtl/cie_irq_ctrl.sv */
// What this block does
// R1: global enable passes or blocks all requests
// R2: group enable gates every peripheral request
// R3: timer a enable lets its flag request
// R4: external pin enable lets its flag request
// R5: port change needs own and pin enables
// R6: timer a flag sticky until software clears
// R7: software initialises timer before clearing flag
// R8: external pin flag sticky until software clears
// R9: port change flag set on enabled change
// R10: upper peripheral enables: gate, converter, rx, tx
// R11: lower enables: sync, capcomp, match, overflow
// R12: flags set regardless of any enable
// R13: software clears stale flags before enabling
// R14: peripheral flags laid out like the enables
// R15: edge select picks rising or falling edge
// R16: accept clears global enable, return sets it
// R17: request is enabled core or peripheral hits
//
// The strobed register port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
// ==========================================================================
// interrupt enable and flag logic, top level
// ==========================================================================
module cie_irq_ctrl (
   // clock, reset, clock enable
   input  wire logic       ref_clk,
   input  wire logic       rst_n,
   input  wire logic       ce,
   // register port
   input  wire logic [2:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic [7:0]      reg_rdata,
   // core interrupt sources
   input  wire logic       timer_a_overflow,
   input  wire logic       ext_pin,
   input  wire logic [7:0] port_pins,
   // peripheral sources, pulses except bits 5 and 4 which are levels
   input  wire logic [7:0] periph_events,
   // processor core
   input  wire logic       irq_accept,
   input  wire logic       return_from_isr,
   output logic            irq_req,
   // block interrupt
   output logic            irq_out
);
   import cie_pkg::*;

   // ========================================================================
   // state and decode
   // ========================================================================
   cie_top_s   s_reg;      // all state of the block
   cie_top_s   s_next;     // next value of all state
   logic       ext_edge;   // edge seen on the external pin
   logic       pc_pulse;   // enabled port pin changed
   logic       wr_ctrl;    // write to interrupt_control
   logic       wr_pie;     // write to peripheral enables
   logic       wr_pir;     // write to peripheral flags
   logic       wr_pcm;     // write to pin change mask
   logic       wr_opt;     // write to option bits
   logic       wr_evt_st;  // write-one-to-clear of events
   logic       wr_evt_mk;  // write to event mask
   logic [7:0] core_en;    // core enables aligned to flags
   logic [7:0] core_fl;    // core flags
   logic [2:0] evt_set;    // block events this cycle
   logic [7:0] pir_set;    // peripheral flag sets this cycle

   // register write decode, one strobe per index
   assign wr_ctrl   = reg_wr && (reg_addr == ADDR_CTRL);
   assign wr_pie    = reg_wr && (reg_addr == ADDR_PIE);
   assign wr_pir    = reg_wr && (reg_addr == ADDR_PIR);
   assign wr_pcm    = reg_wr && (reg_addr == ADDR_PCM);
   assign wr_opt    = reg_wr && (reg_addr == ADDR_OPT);
   assign wr_evt_st = reg_wr && (reg_addr == ADDR_EVT_ST);
   assign wr_evt_mk = reg_wr && (reg_addr == ADDR_EVT_MK);

   // enables sit three bits above their flags
   assign core_en = {5'h00, s_reg.ctrl[BIT_TAE:BIT_PCE]};
   assign core_fl = {5'h00, s_reg.ctrl[BIT_TAF:BIT_PCF]};

   // the two level-driven flags are not sticky, the rest are
   assign pir_set = periph_events & ~PIR_RO;

   // ========================================================================
   // source detectors
   // ========================================================================
   cie_edge_detect u_edge (
      .ref_clk    (ref_clk),
      .rst_n      (rst_n),
      .ce         (ce),
      .pin        (ext_pin),
      .rise_sel   (s_reg.opt[BIT_EDGE]),
      .edge_pulse (ext_edge)
   );

   cie_pin_change u_chg (
      .ref_clk      (ref_clk),
      .rst_n        (rst_n),
      .ce           (ce),
      .pins         (port_pins),
      .mask         (s_reg.pcm),
      .change_pulse (pc_pulse)
   );

   // ========================================================================
   // next state
   // ========================================================================
   // software writes first, hardware sets and core events after them,
   // so an event landing on the clearing write is never lost
   always_comb begin
      s_next = s_reg;
      evt_set = 3'h0;

      // plain control registers
      if (wr_ctrl) begin
         s_next.ctrl = reg_wdata;
      end
      if (wr_pie) begin
         s_next.pie = reg_wdata; // see R10, R11
      end
      if (wr_pcm) begin
         s_next.pcm = reg_wdata;
      end
      if (wr_opt) begin
         s_next.opt = reg_wdata;
      end
      if (wr_evt_mk) begin
         s_next.evt_mk = reg_wdata[2:0];
      end

      // peripheral flags: writable bits take the write, mirrored
      // bits follow their peripheral and ignore software
      if (wr_pir) begin
         s_next.pir = (reg_wdata & ~PIR_RO) | (s_reg.pir & PIR_RO);
      end
      s_next.pir = s_next.pir | pir_set; // see R12, R14
      s_next.pir[BIT_RX] = periph_events[BIT_RX]; // see R14
      s_next.pir[BIT_TX] = periph_events[BIT_TX]; // see R14

      // core flags set whatever the enables say
      if (timer_a_overflow) begin
         s_next.ctrl[BIT_TAF] = 1'b1; // see R6, R12
      end
      if (ext_edge) begin
         s_next.ctrl[BIT_EXF] = 1'b1; // see R8, R12
      end
      if (pc_pulse && s_reg.ctrl[BIT_PCE]) begin
         s_next.ctrl[BIT_PCF] = 1'b1; // see R9
      end else if (pc_pulse) begin
         s_next.ctrl[BIT_PCF] = 1'b1; // see R12
      end

      // core handshake on the global enable; accept beats return
      if (irq_accept) begin
         s_next.ctrl[BIT_GIE] = 1'b0; // see R16
      end else if (return_from_isr) begin
         s_next.ctrl[BIT_GIE] = 1'b1; // see R16
      end

      // service state, only for software to observe
      unique case (s_reg.svc)
         SVC_IDLE: begin
            if (irq_accept) begin
               s_next.svc = SVC_BUSY;
            end
         end
         SVC_BUSY: begin
            if (return_from_isr && !irq_accept) begin
               s_next.svc = SVC_IDLE;
            end
         end
         default: begin
            s_next.svc = SVC_IDLE; // illegal code recovers to idle
         end
      endcase

      // request from the registered flags and enables
      s_next.req = s_reg.ctrl[BIT_GIE] & ( // see R1, R17
         any_hit(core_en, core_fl) | // see R3, R4, R5
         (s_reg.ctrl[BIT_PERIPHERAL_GROUP_ENABLE] & any_hit(s_reg.pie, s_reg.pir))); // see R2

      // block events, sticky, write one to clear, set wins
      evt_set[EVT_REQ] = s_next.req & ~s_reg.req;
      evt_set[EVT_ACK] = irq_accept;
      evt_set[EVT_RET] = return_from_isr;
      if (wr_evt_st) begin
         s_next.evt_st = s_reg.evt_st & ~reg_wdata[2:0];
      end
      s_next.evt_st = s_next.evt_st | evt_set;
      s_next.irq = |(s_reg.evt_st & s_reg.evt_mk);

      // read data stands the cycle after the strobe
      s_next.rdata = 8'h00;
      if (reg_rd) begin
         unique case (reg_addr)
            ADDR_CTRL:   s_next.rdata = s_reg.ctrl;
            ADDR_PIE:    s_next.rdata = s_reg.pie;
            ADDR_PIR:    s_next.rdata = s_reg.pir;
            ADDR_PCM:    s_next.rdata = s_reg.pcm;
            ADDR_OPT:    s_next.rdata = s_reg.opt;
            ADDR_EVT_ST: s_next.rdata = {(s_reg.svc == SVC_BUSY),
                                         4'h0, s_reg.evt_st};
            ADDR_EVT_MK: s_next.rdata = {5'h00, s_reg.evt_mk};
            default:     s_next.rdata = 8'h00; // unmapped reads zero
         endcase
      end
   end

   // ========================================================================
   // state register
   // ========================================================================
   // the port change flag has no defined power-on value on the part;
   // here it clears so simulation starts known
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         s_reg.svc    <= SVC_IDLE;
         s_reg.ctrl   <= CTRL_RST; // see R9
         s_reg.pie    <= PIE_RST;
         s_reg.pir    <= PIR_RST;
         s_reg.pcm    <= PCM_RST;
         s_reg.opt    <= OPT_RST;
         s_reg.evt_st <= EVT_RST;
         s_reg.evt_mk <= EVT_RST;
         s_reg.rdata  <= 8'h00;
         s_reg.req    <= 1'b0;
         s_reg.irq    <= 1'b0;
      end else if (ce) begin
         s_reg <= s_next;
      end
   end

   // outputs straight from the state flops
   assign reg_rdata = s_reg.rdata;
   assign irq_req   = s_reg.req;
   assign irq_out   = s_reg.irq;

   // ========================================================================
   // assertions
   // ========================================================================
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);

   // global enable clear means no request next cycle
   a_gie_blocks_req: assert property ( // see R1
      ce && !s_reg.ctrl[BIT_GIE] |=> !irq_req)
      else $error("request raised with global enable clear");

   // peripheral hit alone needs the group enable
   a_peripheral_group_enable_gates: assert property ( // see R2
      ce && !s_reg.ctrl[BIT_PERIPHERAL_GROUP_ENABLE] && !any_hit(core_en, core_fl)
      |=> !irq_req)
      else $error("peripheral request passed group enable");

   // enabled timer flag requests under global enable
   a_timer_req: assert property ( // see R3
      ce && s_reg.ctrl[BIT_GIE] && s_reg.ctrl[BIT_TAE]
      && s_reg.ctrl[BIT_TAF] |=> irq_req)
      else $error("timer flag did not request");

   // enabled external flag requests under global enable
   a_ext_req: assert property ( // see R4
      ce && s_reg.ctrl[BIT_GIE] && s_reg.ctrl[BIT_EXE]
      && s_reg.ctrl[BIT_EXF] |=> irq_req)
      else $error("external flag did not request");

   // overflow sets the flag and it stays without a write
   a_timer_sticky: assert property ( // see R6
      ce && timer_a_overflow ##1 (!ce || !wr_ctrl)[*2]
      |-> s_reg.ctrl[BIT_TAF])
      else $error("timer flag lost before software cleared it");

   // external flag stays set until a write
   a_ext_sticky: assert property ( // see R8
      ce && ext_edge ##1 (!ce || !wr_ctrl)[*2] |-> s_reg.ctrl[BIT_EXF])
      else $error("external flag lost");

   // a clearing write in the same cycle as the event loses
   a_set_wins: assert property ( // see R12
      ce && wr_ctrl && !reg_wdata[BIT_EXF] && ext_edge
      |=> s_reg.ctrl[BIT_EXF])
      else $error("external event lost to clearing write");

   // change pulse sets the port change flag
   a_port_flag: assert property ( // see R9
      ce && pc_pulse |=> s_reg.ctrl[BIT_PCF])
      else $error("port change flag not set");

   // masked pin cannot produce a change two cycles on
   a_pin_masked: assert property ( // see R5
      ce && (s_reg.pcm == 8'h00) && !wr_pcm ##1 ce |=> !pc_pulse)
      else $error("change reported on masked pins");

   // enabled peripheral flag requests under both enables
   a_periph_req: assert property ( // see R11, R17
      ce && s_reg.ctrl[BIT_GIE] && s_reg.ctrl[BIT_PERIPHERAL_GROUP_ENABLE]
      && any_hit(s_reg.pie, s_reg.pir) |=> irq_req)
      else $error("peripheral flag did not request");

   // accept clears the global enable, return sets it again
   a_accept_clears: assert property ( // see R16
      ce && irq_accept |=> !s_reg.ctrl[BIT_GIE])
      else $error("accept left global enable set");

   // accept is logged in event status
   a_ack_logged: assert property ( // see R16
      ce && irq_accept |=> s_reg.evt_st[EVT_ACK])
      else $error("accept not logged");


   a_return_sets: assert property ( // see R16
      ce && return_from_isr && !irq_accept |=> s_reg.ctrl[BIT_GIE])
      else $error("return did not set global enable");

   // mirrored flags follow the peripheral level
   a_rx_mirror: assert property ( // see R14
      ce |=> s_reg.pir[BIT_RX] == $past(periph_events[BIT_RX]))
      else $error("receive flag does not follow peripheral");
   a_tx_mirror: assert property ( // see R14
      ce |=> s_reg.pir[BIT_TX] == $past(periph_events[BIT_TX]))
      else $error("transmit mirror wrong");

   // pulse sources set flags whatever the enables
   a_pir_set: assert property ( // see R12
      ce |=> (s_reg.pir & $past(pir_set)) == $past(pir_set))
      else $error("peripheral flag not set");

   // read of the control register returns its value
   a_read_ctrl: assert property (
      ce && reg_rd && (reg_addr == ADDR_CTRL)
      |=> reg_rdata == $past(s_reg.ctrl))
      else $error("control read returned wrong data");

   // read data is zero without a read
   a_rdata_idle: assert property (
      ce && !reg_rd |=> reg_rdata == 8'h00)
      else $error("read data without a read");

   // main scenarios
   c_accept: cover property (irq_req ##[1:8] irq_accept);
   c_ext_edge: cover property (ce && ext_edge ##1 s_reg.ctrl[BIT_EXF]);
   c_periph: cover property (ce && s_reg.ctrl[BIT_PERIPHERAL_GROUP_ENABLE] ##1 irq_req);
   c_irq_out: cover property (irq_out);

endmodule

/* File: sim/cie_core_model.sv */
`timescale 1ns/10ps
// ==========================================================================
// processor core model: takes requests, serves them, returns
// ==========================================================================
module cie_core_model (
   // clock and reset
   input  wire logic       ref_clk,
   input  wire logic       rst_n,
   // test controls: serve enable, accept delay, service length
   input  wire logic       serve,
   input  wire logic [4:0] acc_dly,
   input  wire logic [4:0] svc_len,
   // request in, handshake pulses out
   input  wire logic       irq_req,
   output logic            irq_accept,
   output logic            return_from_isr,
   output int              n_accept
);
   logic       busy_reg; // inside a service routine
   logic [4:0] cnt_reg;  // cycles spent in the current phase
   // ==========================================================================
   // handshake; a request that drops during the delay is simply lost,
   // since a real core only looks at the line when it is ready
   always @(posedge ref_clk) begin
      irq_accept      <= rst_n && !busy_reg && serve && irq_req
                         && cnt_reg == acc_dly;
      return_from_isr <= rst_n && busy_reg && cnt_reg == svc_len;
      if (!rst_n) begin
         busy_reg <= 1'b0;
         cnt_reg  <= 5'h00;
         n_accept <= 0;
      end else if (!busy_reg) begin
         if (serve && irq_req && cnt_reg == acc_dly) begin
            busy_reg   <= 1'b1;
            cnt_reg    <= 5'h00;
            n_accept   <= n_accept + 1;
         end else begin
            cnt_reg <= (serve && irq_req) ? cnt_reg + 5'h01 : 5'h00;
         end
      end else if (cnt_reg == svc_len) begin
         busy_reg        <= 1'b0;
         cnt_reg         <= 5'h00;
      end else begin
         cnt_reg <= cnt_reg + 5'h01; // still serving
      end
   end
endmodule

/* File: sim/cie_irq_ctrl_tb.sv */
`timescale 1ns/10ps
// ==========================================================================
// self-checking bench for the interrupt enable and flag logic
// ==========================================================================
module cie_irq_ctrl_tb;
   import cie_pkg::*;
   logic       ref_clk = 0, rst_n = 0, ce = 1;  // clock, reset, run
   logic [2:0] reg_addr = 0;                     // register port
   logic [7:0] reg_wdata = 0, reg_rdata;
   logic       reg_wr = 0, reg_rd = 0;
   logic       timer_a_overflow = 0, ext_pin = 0; // core sources
   logic [7:0] port_pins = 0, periph_events = 0;
   logic       irq_accept, return_from_isr, irq_req, irq_out;
   logic       serve = 0;                        // core model controls
   logic [4:0] acc_dly = 0, svc_len = 20;
   int         n_accept, start, k, cycles = 0;
   int         mismatches = 0, num_checks = 0;

   always #20 ref_clk = ~ref_clk; // 25 MHz

   cie_irq_ctrl cie_irq_ctrl_i (.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .timer_a_overflow(timer_a_overflow), .ext_pin(ext_pin),
      .port_pins(port_pins), .periph_events(periph_events),
      .irq_accept(irq_accept), .return_from_isr(return_from_isr),
      .irq_req(irq_req), .irq_out(irq_out));

   cie_core_model cie_core_model_i (.ref_clk(ref_clk), .rst_n(rst_n),
      .serve(serve), .acc_dly(acc_dly), .svc_len(svc_len),
      .irq_req(irq_req), .irq_accept(irq_accept),
      .return_from_isr(return_from_isr), .n_accept(n_accept));

   // ==========================================================================
   // compare and report
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // each access leaves a gap cycle, so no strobe is assigned twice at once
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [2:0] a, input logic [7:0] exp);
      @(posedge ref_clk);
      reg_rd <= 1'b1; reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, exp);
   endtask
   // level outputs lag their cause by one edge, so wait one
   task automatic lvl_is(input logic out_sel, input logic exp);
      @(posedge ref_clk);
      #1 chk({7'h0, out_sel ? irq_out : irq_req}, {7'h0, exp});
   endtask
   // pins move, then wait out the two-cycle detector latency
   task automatic pins(input logic e, input logic [7:0] p);
      @(posedge ref_clk);
      ext_pin <= e; port_pins <= p;
      repeat (3) @(posedge ref_clk);
   endtask
   task automatic tick_timer;
      @(posedge ref_clk) timer_a_overflow <= 1'b1;
      @(posedge ref_clk) timer_a_overflow <= 1'b0;
   endtask
   task end_sim;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // hang guard, well above the roughly 500 cycles the run needs
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 6000) begin
         mismatches++;
         end_sim;
      end
   end

   // ==========================================================================
   // main sequence
   initial begin
      repeat (5) @(posedge ref_clk);
      rst_n <= 1'b1;
      rd(ADDR_CTRL, 8'h00);
      rd(ADDR_PIE, 8'h00);
      wr(ADDR_PIE, 8'hff);
      rd(ADDR_PIE, 8'hff);
      wr(3'h7, 8'hff);
      rd(3'h7, 8'h00);                 // unmapped place reads zero
      // timer source: flag with all interrupt_control enables off, then gating
      tick_timer;
      repeat (5) @(posedge ref_clk);
      rd(ADDR_CTRL, 8'h04);
      wr(ADDR_CTRL, 8'h84); lvl_is(0, 1'b0);
      wr(ADDR_CTRL, 8'ha4); lvl_is(0, 1'b1);
      wr(ADDR_CTRL, 8'h24); lvl_is(0, 1'b0);
      wr(ADDR_CTRL, 8'h00);            // timer assumed set up
      rd(ADDR_CTRL, 8'h00);
      // external pin, falling then rising edge select
      wr(ADDR_CTRL, 8'h10);
      pins(1'b1, 8'h00); rd(ADDR_CTRL, 8'h10);
      pins(1'b0, 8'h00); rd(ADDR_CTRL, 8'h12);
      wr(ADDR_CTRL, 8'h92); lvl_is(0, 1'b1);
      wr(ADDR_CTRL, 8'h82); lvl_is(0, 1'b0);
      wr(ADDR_CTRL, 8'h00);
      wr(ADDR_OPT, 8'h40);
      pins(1'b1, 8'h00); rd(ADDR_CTRL, 8'h02);
      wr(ADDR_CTRL, 8'h00); rd(ADDR_CTRL, 8'h00);
      // port change, only pin 2 enabled in the mask
      wr(ADDR_PCM, 8'h04);
      pins(1'b1, 8'h08); rd(ADDR_CTRL, 8'h00);
      pins(1'b1, 8'h0c); rd(ADDR_CTRL, 8'h01);
      wr(ADDR_CTRL, 8'h81); lvl_is(0, 1'b0);
      wr(ADDR_CTRL, 8'h89); lvl_is(0, 1'b1);
      wr(ADDR_CTRL, 8'h00); rd(ADDR_CTRL, 8'h00);
      // a clearing write on the setting edge loses
      @(posedge ref_clk) ext_pin <= 1'b0;
      @(posedge ref_clk) ext_pin <= 1'b1;
      wr(ADDR_CTRL, 8'h00); rd(ADDR_CTRL, 8'h02);
      wr(ADDR_CTRL, 8'h00);
      // clock enable low: the block ignores a timer pulse
      @(posedge ref_clk) ce <= 1'b0;
      tick_timer;
      @(posedge ref_clk) ce <= 1'b1;
      rd(ADDR_CTRL, 8'h00);
      // each peripheral source; bits 5 and 4 are held levels
      for (int i = 0; i < 8; i++) begin
         wr(ADDR_PIE, 8'h01 << i);     // flags already clear
         @(posedge ref_clk) periph_events <= 8'h01 << i;
         if (i != 4 && i != 5) @(posedge ref_clk) periph_events <= 8'h00;
         repeat (2) @(posedge ref_clk);
         rd(ADDR_PIR, 8'h01 << i);
         wr(ADDR_CTRL, 8'h80); lvl_is(0, 1'b0);
         wr(ADDR_CTRL, 8'hc0); lvl_is(0, 1'b1);
         wr(ADDR_CTRL, 8'h40); lvl_is(0, 1'b0);
         wr(ADDR_PIE, ~(8'h01 << i));
         wr(ADDR_CTRL, 8'hc0); lvl_is(0, 1'b0);
         wr(ADDR_CTRL, 8'h00);
         wr(ADDR_PIR, 8'h00);
         rd(ADDR_PIR, (8'h01 << i) & PIR_RO); // mirrors refuse writes
         @(posedge ref_clk) periph_events <= 8'h00;
         wr(ADDR_PIR, 8'h00);
         rd(ADDR_PIR, 8'h00);
      end
      // core handshake, prompt and slow acceptance
      for (int d = 0; d < 2; d++) begin
         wr(ADDR_EVT_ST, 8'h07);
         wr(ADDR_CTRL, 8'ha0);
         acc_dly <= d ? 5'h06 : 5'h00;
         serve   <= 1'b1;
         start = n_accept;
         tick_timer;
         k = 0;
         while (n_accept == start && k < 100) begin
            @(posedge ref_clk);
            k++;
         end
         chk(8'(n_accept - start), 8'h01);
         rd(ADDR_CTRL, 8'h24);
         wr(ADDR_CTRL, 8'h20);         // flag cleared inside service
         repeat (30) @(posedge ref_clk);
         rd(ADDR_CTRL, 8'ha0);
         lvl_is(0, 1'b0);
         serve <= 1'b0;
         rd(ADDR_EVT_ST, 8'h07);
      end
      // block interrupt: masked, unmasked, cleared
      lvl_is(1, 1'b0);
      wr(ADDR_EVT_MK, 8'h02); lvl_is(1, 1'b1);
      wr(ADDR_EVT_ST, 8'h02); lvl_is(1, 1'b0);
      rd(ADDR_EVT_ST, 8'h05);
      wr(ADDR_EVT_MK, 8'h00);
      end_sim;
   end
endmodule
